// *** dv/pbt_replier_test.sv ***
// self-checking bench for the transfer-cycle replier
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("wrong value at %0t: got %0h expected %0h", $time, (g), (e)); end end
module pbt_replier_test;
  logic i_clk, i_rst_n, i_busy, i_wr_ready, i_rd_valid, i_rd_err, lock_on, drain, bc_on, exc;
  logic [31:0] ad_n, o_ad_n, o_rd_addr, hs_data;
  logic [31:0] rnd = 32'h0001_5F24;
  logic [31:0] i_rd_data = 32'h5A5A_0000;
  logic [9:0] sc_n;
  logic [3:0] o_sc_n, o_sc_oe_n;
  logic o_ad_oe_n, o_wr_valid, o_rd_take, o_arb_hold, o_local_block;
  logic [2:0] hs_code, ec;
  pbt_pkg::pbt_word_t o_wr_word;
  int hs_cnt, hs_seen, error_cnt, checks, rd_exp, rd_idx, n;
  pbt_pkg::pbt_word_t exp_w[$];
  logic [2:0] exp_c[$];
  logic [31:0] exp_d[$];
  logic [31:0] exp_a[$];

  pbt_replier pbt_replier_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_sc_n(sc_n),
    .o_sc_n(o_sc_n), .o_sc_oe_n(o_sc_oe_n), .i_ad_n(ad_n), .o_ad_n(o_ad_n),
    .o_ad_oe_n(o_ad_oe_n), .i_exc(exc), .i_busy(i_busy), .o_wr_valid(o_wr_valid),
    .i_wr_ready(i_wr_ready), .o_wr_word(o_wr_word), .i_rd_valid(i_rd_valid),
    .i_rd_data(i_rd_data), .i_rd_err(i_rd_err), .o_rd_take(o_rd_take),
    .o_rd_addr(o_rd_addr), .o_arb_hold(o_arb_hold), .o_local_block(o_local_block));
  pbt_requester pbt_requester_i (.i_clk(i_clk), .i_lock(lock_on), .i_sc_n(o_sc_n),
    .i_sc_oe_n(o_sc_oe_n), .i_ad_n(o_ad_n), .i_ad_oe_n(o_ad_oe_n), .o_sc_n(sc_n),
    .o_ad_n(ad_n), .o_code(hs_code), .o_data(hs_data), .o_hs_cnt(hs_cnt));

  // ------------------------------------------------------------
  // clock, random source, local side
  // ------------------------------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  // local sink pops at random so the buffer sees stalls
  always @(posedge i_clk) begin
    rnd <= xs(rnd);
    i_wr_ready <= drain & rnd[0];
    if (o_rd_take === 1'b1) begin
      rd_idx <= rd_idx + 1;
      i_rd_data <= 32'h5A5A_0000 + 32'(rd_idx + 1);
    end
  end

  // watcher: oldest note against what the outputs show
  always @(posedge i_clk) begin
    if (o_wr_valid === 1'b1 && i_wr_ready === 1'b1) begin
      `CHK(o_wr_word, exp_w[0])
      void'(exp_w.pop_front());
    end
    // a captured read word carries the address of its own beat
    if (o_rd_take === 1'b1) begin
      `CHK(o_rd_addr, exp_a[0])
      void'(exp_a.pop_front());
    end
    if (hs_cnt != hs_seen) begin
      hs_seen <= hs_cnt;
      ec = exp_c.pop_front();
      `CHK(hs_code, ec)
      if (ec == pbt_pkg::ERR_NONE) `CHK(hs_data, exp_d[0])
      void'(exp_d.pop_front());
    end
    if (bc_on) `CHK(o_sc_oe_n, pbt_pkg::SC_OE_N_RST)
  end

  // ------------------------------------------------------------
  // stimulus and verdict
  // ------------------------------------------------------------
  // note the expected hand-overs and words, then run the cycle
  task automatic go(input logic wr, bc, input logic [1:0] sp, w, input logic [31:0] a,
                    input int nb, input logic [2:0] e, input int eb);
    logic [31:0] d0, ai;
    d0 = xs(rnd ^ a);
    for (int i = 0; i < nb; i++) begin
      ai = (sp == pbt_pkg::SP_MEM) ? a + 32'(i) * (32'(pbt_pkg::W_BYTES_MAX) - 32'(w)) : a;
      if (!wr) exp_a.push_back(ai);
      if (i == eb) begin
        exp_c.push_back(e);
        exp_d.push_back(32'h0);
        if (i != nb - 1) exp_c.push_back(e);
        if (i != nb - 1) exp_d.push_back(32'h0);
        break;
      end
      exp_c.push_back(pbt_pkg::ERR_NONE);
      exp_d.push_back(wr ? d0 + 32'(i) : 32'h5A5A_0000 + 32'(rd_exp));
      if (!wr) rd_exp++;
      if (wr) exp_w.push_back('{ai, d0 + 32'(i), i == nb - 1});
    end
    i_rd_valid <= ~wr;
    pbt_requester_i.xfer(wr, bc, sp, w, a, d0, nb);
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // watchdog well beyond the expected run length
  initial begin
    repeat (20000) @(posedge i_clk);
    error_cnt++;
    end_sim();
  end

  // main sequence
  initial begin
    {i_rst_n, i_busy, i_rd_valid, i_rd_err, lock_on, drain, bc_on, exc} = 8'h00;
    {error_cnt, checks, rd_exp} = '0;
    repeat (4) @(posedge i_clk);
    i_rst_n <= 1'b1;
    drain <= 1'b1;
    @(posedge i_clk);
    for (int w = 0; w < 4; w++) begin
      n = (w == 1) ? 1 : 3;
      go(1, 0, pbt_pkg::SP_MEM, 2'(w), 32'h0000_0100, n, pbt_pkg::ERR_NONE, -1);
    end
    go(1, 0, pbt_pkg::SP_IO, pbt_pkg::W_16, 32'h0000_0040, 2, pbt_pkg::ERR_NONE, -1);
    go(1, 0, pbt_pkg::SP_MSG, pbt_pkg::W_32, 32'h0000_0301, 2, pbt_pkg::ERR_NONE, -1);
    go(1, 0, pbt_pkg::SP_IC, pbt_pkg::W_8, 32'h0000_0804, 1, pbt_pkg::ERR_NONE, -1);
    go(0, 0, pbt_pkg::SP_MEM, pbt_pkg::W_32, 32'h0000_0180, 3, pbt_pkg::ERR_NONE, -1);
    bc_on <= 1'b1;
    // broadcast only to message destination ff
    go(1, 1, pbt_pkg::SP_MSG, pbt_pkg::W_32, 32'h0000_02FF, 2, pbt_pkg::ERR_NONE, -1);
    bc_on <= 1'b0;
    lock_on <= 1'b1;
    go(1, 0, pbt_pkg::SP_MEM, pbt_pkg::W_32, 32'h0000_0100, 1, pbt_pkg::ERR_NONE, -1);
    `CHK(o_arb_hold, 1'b1)
    `CHK(o_local_block, 1'b1)
    lock_on <= 1'b0;
    repeat (3) @(posedge i_clk);
    `CHK(o_local_block, 1'b0)
    // a word left in the buffer would shorten the stall count below
    while (o_wr_valid === 1'b1) @(posedge i_clk);
    n = hs_cnt;
    drain <= 1'b0;
    fork
      go(1, 0, pbt_pkg::SP_MEM, pbt_pkg::W_32, 32'h0000_0200, 10, pbt_pkg::ERR_NONE, -1);
      begin
        repeat (60) @(posedge i_clk);
        `CHK(hs_cnt - n, pbt_pkg::FIFO_DEPTH)
        drain <= 1'b1;
      end
    join
    i_busy <= 1'b1;
    go(1, 0, pbt_pkg::SP_IO, pbt_pkg::W_32, 32'h0000_0040, 2, pbt_pkg::ERR_NACK, 0);
    // exception outranks the nack: no answer at all, the requester times out
    exc <= 1'b1;
    go(1, 0, pbt_pkg::SP_IO, pbt_pkg::W_32, 32'h0000_0040, 1, 3'h0, 0);
    exc <= 1'b0;
    go(1, 0, pbt_pkg::SP_MSG, pbt_pkg::W_8, 32'h0000_0301, 1, pbt_pkg::ERR_TNU, 0);
    i_busy <= 1'b0;
    go(1, 0, pbt_pkg::SP_MEM, pbt_pkg::W_24, 32'h0000_0100, 2, pbt_pkg::ERR_TNU, 1);
    go(1, 0, pbt_pkg::SP_IC, pbt_pkg::W_8, 32'h0000_0804, 2, pbt_pkg::ERR_CONT, 1);
    go(1, 0, pbt_pkg::SP_IO, pbt_pkg::W_8, 32'h0000_0040, 1, pbt_pkg::ERR_NONE, -1);
    i_rd_err <= 1'b1;
    go(0, 0, pbt_pkg::SP_MEM, pbt_pkg::W_32, 32'h0000_0180, 2, pbt_pkg::ERR_DATA, 0);
    i_rd_err <= 1'b0;
    repeat (20) @(posedge i_clk);
    // every noted word, handshake and read address must have shown up
    `CHK(exp_w.size() + exp_c.size() + exp_a.size(), 0)
    end_sim();
  end
endmodule
`default_nettype wire

// *** dv/pbt_requester.sv ***
// requesting agent model that drives the shared control and address/data lines
`timescale 1ns/1ps
`default_nettype none
module pbt_requester (
  input wire logic i_clk,
  input wire logic i_lock,
  input wire logic [3:0] i_sc_n,
  input wire logic [3:0] i_sc_oe_n,
  input wire logic [31:0] i_ad_n,
  input wire logic i_ad_oe_n,
  output logic [9:0] o_sc_n,
  output logic [31:0] o_ad_n,
  output logic [2:0] o_code,
  output logic [31:0] o_data,
  output int o_hs_cnt
);
  logic [9:0] sc_q = 10'h3FF;
  logic [31:0] ad_q = 32'hFFFF_FFFF;

  initial o_hs_cnt = 0;

  // ------------------------------------------------------------
  // wired bus: lines pulled high, any low driver wins
  // ------------------------------------------------------------
  // control lines, with the lock line taken from i_lock
  assign o_sc_n = {sc_q[9:8], sc_q[7:4] & (i_sc_oe_n | i_sc_n), sc_q[3:2], ~i_lock, sc_q[0]};
  assign o_ad_n = ad_q & (i_ad_oe_n ? 32'hFFFF_FFFF : i_ad_n);

  // ------------------------------------------------------------
  // transfer tasks
  // ------------------------------------------------------------
  // wait for replier ready, bounded so a dead replier cannot hang us
  task automatic shake(output logic [2:0] c);
    int k;
    k = 0;
    do begin
      @(posedge i_clk);
      k++;
    end while (o_sc_n[4] !== 1'b0 && k < 500);
    c = (o_sc_n[4] === 1'b0) ? o_sc_n[7:5] : 3'h0;
    o_code <= c;
    o_data <= ~o_ad_n;
    o_hs_cnt <= o_hs_cnt + 1;
  endtask

  // one transfer cycle: request phase, then nb data hand-overs
  task automatic xfer(input logic wr, bc, input logic [1:0] sp, w,
                      input logic [31:0] a, d0, input int nb);
    logic [2:0] c;
    sc_q <= {3'h7, ~wr, sp, w, 2'h2};
    ad_q <= ~a;
    @(posedge i_clk);
    for (int i = 0; i < nb; i++) begin
      sc_q <= {6'h3F, 1'b0, i != nb - 1, 2'h3};
      ad_q <= wr ? ~(d0 + 32'(i)) : 32'hFFFF_FFFF;
      if (bc) begin
        repeat (7) @(posedge i_clk);
        sc_q[4] <= 1'b0;
      end
      shake(c);
      if (c != pbt_pkg::ERR_NONE && i != nb - 1) begin
        sc_q[2] <= 1'b0;
        shake(c);
      end
      if (c != pbt_pkg::ERR_NONE) break;
    end
    sc_q <= 10'h3FF;
    ad_q <= 32'hFFFF_FFFF;
    @(posedge i_clk);
  endtask
endmodule
`default_nettype wire

// *** inc/pbt_pkg.sv ***
// shared constants and types for the parallel bus transfer-cycle replier
package pbt_pkg;

  // ----------------------------------------------------------------
  // system control line positions (all lines active low on the bus)
  // ----------------------------------------------------------------
  localparam int SC_REQ = 0;    // low while the request phase is on the bus
  localparam int SC_LOCK = 1;
  localparam int SC_EOC = 2;
  localparam int SC_RQRDY = 3;
  localparam int SC_RPRDY = 4;
  localparam int SC_DIR = 6;    // low in the request phase marks a write

  // ----------------------------------------------------------------
  // request phase encodings, as line levels
  // ----------------------------------------------------------------
  localparam logic [1:0] SP_MEM = 2'h3;  // {sc5, sc4}
  localparam logic [1:0] SP_IO = 2'h2;
  localparam logic [1:0] SP_MSG = 2'h1;
  localparam logic [1:0] SP_IC = 2'h0;
  localparam logic [1:0] W_8 = 2'h3;     // {sc3, sc2}
  localparam logic [1:0] W_16 = 2'h2;
  localparam logic [1:0] W_24 = 2'h1;
  localparam logic [1:0] W_32 = 2'h0;
  localparam logic [2:0] W_BYTES_MAX = 3'h4;
  localparam logic [7:0] BCAST_DEST = 8'hFF;

  // ----------------------------------------------------------------
  // agent error codes, line levels {sc7, sc6, sc5}
  // ----------------------------------------------------------------
  localparam logic [2:0] ERR_NONE = 3'h7;
  localparam logic [2:0] ERR_NACK = 3'h3;
  localparam logic [2:0] ERR_WIDTH = 3'h6;
  localparam logic [2:0] ERR_CONT = 3'h5;
  localparam logic [2:0] ERR_DATA = 3'h2;
  localparam logic [2:0] ERR_TNU = 3'h4;

  // ----------------------------------------------------------------
  // reset values of the pin drivers
  // ----------------------------------------------------------------
  localparam logic [3:0] SC_LVL_RST = 4'hF;   // {sc7..sc4} released high
  localparam logic [3:0] SC_OE_N_RST = 4'hF;  // nothing driven
  localparam int FIFO_DEPTH = 8;

  typedef enum {PBT_IDLE, PBT_DATA, PBT_ERR} pbt_state_t;

  // operation parameters held for the whole transfer cycle, except addr, which steps on each memory space beat
  typedef struct packed {
    logic write;
    logic [1:0] space;
    logic [1:0] width;
    logic bcast;
    logic [31:0] addr;
  } pbt_req_t;

  // one received write word as handed to the local side
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
    logic last;
  } pbt_word_t;

endpackage

// *** rtl/pbt_fifo.sv ***
// synchronous fifo with registered valid and ready flags
`timescale 1ns/1ps
`default_nettype none
module pbt_fifo #(
  parameter int WIDTH = 65,
  parameter int DEPTH = 8
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
      $error("pbt_fifo: depth must be a power of two of at least 2");
    end
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0] cnt_q, cnt_d;
  logic room_q, room_d, avail_q, avail_d;
  logic push, pop;

  // ----------------------------------------------------------------
  // pointers and flags
  // ----------------------------------------------------------------
  // flags are registered in their port sense so both ports come straight from flops
  always_comb begin
    push = i_in_valid && room_q;
    pop = i_out_ready && avail_q;
    wr_d = push ? wr_q + 1'b1 : wr_q;
    rd_d = pop ? rd_q + 1'b1 : rd_q;
    cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    room_d = (cnt_d != DEPTH[AW:0]);
    avail_d = (cnt_d != '0);
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      room_q <= 1'b1;
      avail_q <= 1'b0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
      room_q <= room_d;
      avail_q <= avail_d;
    end
  end

  // storage has no reset; nothing reads a slot before it is written
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_q[wr_q] <= i_in_data;
    end
  end

  assign o_in_ready = room_q;
  assign o_out_valid = avail_q;
  assign o_out_data = mem_q[rd_q];
endmodule
`default_nettype wire

// *** rtl/pbt_replier.sv ***
// replying agent for transfer cycles on the parallel system bus
`timescale 1ns/1ps
`default_nettype none
module pbt_replier #(
  parameter int MAX_BYTES = 4,
  parameter int MAX_BEATS = 16,
  parameter int MEM_AW = 20,
  parameter logic [31:0] MEM_BASE = 32'h0000_0000,
  parameter logic MEM_RO = 1'b0,
  parameter int IO_AW = 8,
  parameter logic [15:0] IO_BASE = 16'h0000,
  parameter logic [7:0] MSG_ID = 8'h01,
  parameter logic [4:0] SLOT_ID = 5'h01
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [9:0] i_sc_n,
  output logic [3:0] o_sc_n,
  output logic [3:0] o_sc_oe_n,
  input wire logic [31:0] i_ad_n,
  output logic [31:0] o_ad_n,
  output logic o_ad_oe_n,
  input wire logic i_exc,
  input wire logic i_busy,
  output logic o_wr_valid,
  input wire logic i_wr_ready,
  output pbt_pkg::pbt_word_t o_wr_word,
  input wire logic i_rd_valid,
  input wire logic [31:0] i_rd_data,
  input wire logic i_rd_err,
  output logic o_rd_take,
  output logic [31:0] o_rd_addr,
  output logic o_arb_hold,
  output logic o_local_block
);
  initial begin
    if (MAX_BYTES < 1 || MAX_BYTES > 4 || MAX_BEATS < 1 || MAX_BEATS > 255 ||
        MEM_AW < 1 || MEM_AW > 31 || IO_AW < 1 || IO_AW > 15) begin
      $error("pbt_replier: parameter out of range");
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  // ----------------------------------------------------------------
  // bus view; the bus runs on i_clk, so lines are used as sampled
  // ----------------------------------------------------------------
  logic lock, eoc, rqr, req_ph, sc4_on;
  logic [1:0] space_c, width_c;
  logic wr_c, bcast_c, sel_c, tnu_c, werr_c, hs;
  logic [2:0] wbytes_c, rq_err;
  logic [31:0] addr_c;

  pbt_pkg::pbt_state_t state_q, state_d;
  pbt_pkg::pbt_req_t req_q, req_d;
  logic [2:0] pend_q, pend_d;
  logic [7:0] beats_q, beats_d;
  logic [3:0] lvl_q, lvl_d, oe_n_q, oe_n_d;
  logic [31:0] ad_q, ad_d;
  logic ad_oe_n_q, ad_oe_n_d, take_q, take_d;
  logic hold_q, hold_d, block_q, block_d;
  logic push, fifo_rdy;
  pbt_pkg::pbt_word_t push_word;

  assign lock = !i_sc_n[pbt_pkg::SC_LOCK];
  assign eoc = !i_sc_n[pbt_pkg::SC_EOC];
  assign rqr = !i_sc_n[pbt_pkg::SC_RQRDY];
  assign req_ph = !i_sc_n[pbt_pkg::SC_REQ];
  assign sc4_on = !lvl_q[0];
  assign addr_c = ~i_ad_n;

  // ----------------------------------------------------------------
  // request phase decode
  // ----------------------------------------------------------------
  // space decode
  assign space_c = {i_sc_n[5], i_sc_n[4]};
  assign width_c = {i_sc_n[3], i_sc_n[2]};
  assign wr_c = !i_sc_n[pbt_pkg::SC_DIR];
  assign wbytes_c = pbt_pkg::W_BYTES_MAX - {1'b0, width_c};
  // broadcast is a message write to ff
  assign bcast_c = (space_c == pbt_pkg::SP_MSG) && wr_c &&
                   (addr_c[7:0] == pbt_pkg::BCAST_DEST);

  // address match per space; both low is interconnect
  always_comb begin
    case (space_c)
      pbt_pkg::SP_MEM: sel_c = (addr_c[31:MEM_AW] == MEM_BASE[31:MEM_AW]);
      pbt_pkg::SP_IO: sel_c = (addr_c[15:IO_AW] == IO_BASE[15:IO_AW]);
      pbt_pkg::SP_MSG: sel_c = bcast_c || (addr_c[7:0] == MSG_ID);
      pbt_pkg::SP_IC: sel_c = (addr_c[15:11] == SLOT_ID);
      default: sel_c = 1'b0;
    endcase
  end

  assign tnu_c = ((space_c == pbt_pkg::SP_MSG) && (width_c != pbt_pkg::W_32 || !wr_c)) ||
                 ((space_c == pbt_pkg::SP_IC) && (width_c != pbt_pkg::W_8)) ||
                 ((space_c == pbt_pkg::SP_MEM) && wr_c && MEM_RO);
  assign werr_c = ({29'h0, wbytes_c} > MAX_BYTES);

  // request errors: not understood, then width, then nack
  always_comb begin
    if (tnu_c) begin
      rq_err = pbt_pkg::ERR_TNU;
    end else if (werr_c) begin
      rq_err = pbt_pkg::ERR_WIDTH;
    end else if (i_busy) begin
      rq_err = pbt_pkg::ERR_NACK;
    end else begin
      rq_err = pbt_pkg::ERR_NONE;
    end
  end

  // in a broadcast the requester drives sc4 itself
  assign hs = rqr && (req_q.bcast ? !i_sc_n[pbt_pkg::SC_RPRDY] : sc4_on);

  // ----------------------------------------------------------------
  // transfer cycle state machine
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    req_d = req_q;
    pend_d = pend_q;
    beats_d = beats_q;
    lvl_d = lvl_q;
    oe_n_d = oe_n_q;
    ad_d = ad_q;
    ad_oe_n_d = ad_oe_n_q;
    take_d = 1'b0;
    push = 1'b0;
    case (state_q)
      pbt_pkg::PBT_IDLE: begin
        lvl_d = pbt_pkg::SC_LVL_RST;
        oe_n_d = pbt_pkg::SC_OE_N_RST;
        ad_oe_n_d = 1'b1;
        if (req_ph && sel_c && !i_exc) begin
          req_d = '{write: wr_c, space: space_c, width: width_c,
                    bcast: bcast_c, addr: addr_c};
          beats_d = '0;
          pend_d = pbt_pkg::ERR_NONE;
          if (bcast_c) begin
            state_d = pbt_pkg::PBT_DATA;
          end else if (rq_err != pbt_pkg::ERR_NONE) begin
            // ready plus code on the first handshake
            state_d = pbt_pkg::PBT_ERR;
            lvl_d = {rq_err, 1'b0};
            oe_n_d = 4'h0;
          end else begin
            state_d = pbt_pkg::PBT_DATA;
            oe_n_d = 4'h0;
          end
        end
      end
      pbt_pkg::PBT_DATA: begin
        if (hs) begin
          lvl_d[0] = 1'b1;
          beats_d = beats_q + 8'h01;
          if (req_q.space == pbt_pkg::SP_MEM) begin
            req_d.addr = req_q.addr + {29'h0, wbytes_of(req_q.width)};
          end
          if (eoc) begin
            state_d = pbt_pkg::PBT_IDLE;
          end else if (req_q.width == pbt_pkg::W_24 && !req_q.bcast) begin
            pend_d = pbt_pkg::ERR_TNU;
          end else if ((req_q.space == pbt_pkg::SP_IC ||
                       beats_d >= MAX_BEATS[7:0]) && !req_q.bcast) begin
            // next beat would overrun this agent
            pend_d = pbt_pkg::ERR_CONT;
          end
          // broadcast data only taken, never driven
          push = req_q.write && fifo_rdy;
        end else if (req_q.bcast) begin
          lvl_d = pbt_pkg::SC_LVL_RST;
        end else if (pend_q != pbt_pkg::ERR_NONE && rqr) begin
          state_d = pbt_pkg::PBT_ERR;
          lvl_d = {pend_q, 1'b0};
        end else if (req_q.write) begin
          // hold ready off while the fifo is full
          lvl_d[0] = !(fifo_rdy && pend_q == pbt_pkg::ERR_NONE);
        end else if (!sc4_on && !take_q && i_rd_valid && pend_q == pbt_pkg::ERR_NONE) begin
          ad_d = ~i_rd_data;
          ad_oe_n_d = 1'b0;
          take_d = 1'b1;
          if (i_rd_err) begin
            // data error on the handshake with that data
            state_d = pbt_pkg::PBT_ERR;
            lvl_d = {pbt_pkg::ERR_DATA, 1'b0};
          end else begin
            lvl_d[0] = 1'b0;
          end
        end
        if (i_exc) begin
          state_d = pbt_pkg::PBT_IDLE;
          lvl_d = pbt_pkg::SC_LVL_RST;
          oe_n_d = pbt_pkg::SC_OE_N_RST;
          ad_oe_n_d = 1'b1;
          push = 1'b0;
        end
      end
      pbt_pkg::PBT_ERR: begin
        ad_oe_n_d = req_q.write;
        // end of cycle releases only this cycle
        if ((eoc && rqr) || i_exc) begin
          state_d = pbt_pkg::PBT_IDLE;
          lvl_d = pbt_pkg::SC_LVL_RST;
          oe_n_d = pbt_pkg::SC_OE_N_RST;
          ad_oe_n_d = 1'b1;
        end
      end
      default: begin
        state_d = pbt_pkg::PBT_IDLE;
      end
    endcase
  end

  function automatic logic [2:0] wbytes_of(input logic [1:0] w);
    wbytes_of = pbt_pkg::W_BYTES_MAX - {1'b0, w};
  endfunction

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= pbt_pkg::PBT_IDLE;
      req_q <= '0;
      pend_q <= pbt_pkg::ERR_NONE;
      beats_q <= '0;
      lvl_q <= pbt_pkg::SC_LVL_RST;
      oe_n_q <= pbt_pkg::SC_OE_N_RST;
      ad_q <= '0;
      ad_oe_n_q <= 1'b1;
      take_q <= 1'b0;
    end else begin
      state_q <= state_d;
      req_q <= req_d;
      pend_q <= pend_d;
      beats_q <= beats_d;
      lvl_q <= lvl_d;
      oe_n_q <= oe_n_d;
      ad_q <= ad_d;
      ad_oe_n_q <= ad_oe_n_d;
      take_q <= take_d;
    end
  end

  // ----------------------------------------------------------------
  // lock tracking
  // ----------------------------------------------------------------
  // block stays up until unlock even after our cycle is over
  always_comb begin
    hold_d = lock;
    // local port shut while locked access is open
    block_d = lock && (block_q || state_q != pbt_pkg::PBT_IDLE);
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hold_q <= 1'b0;
      block_q <= 1'b0;
    end else begin
      hold_q <= hold_d;
      block_q <= block_d;
    end
  end

  // ----------------------------------------------------------------
  // write data buffer
  // ----------------------------------------------------------------
  // outside a broadcast a full fifo withholds sc4, which stalls the requester; in a broadcast the word is dropped
  assign push_word = '{addr: req_q.addr, data: addr_c, last: eoc};

  pbt_fifo #(
    .WIDTH($bits(pbt_pkg::pbt_word_t)),
    .DEPTH(pbt_pkg::FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_in_valid(push),
    .o_in_ready(fifo_rdy),
    .i_in_data(push_word),
    .o_out_valid(o_wr_valid),
    .i_out_ready(i_wr_ready),
    .o_out_data(o_wr_word)
  );

  assign o_sc_n = lvl_q;
  assign o_sc_oe_n = oe_n_q;
  assign o_ad_n = ad_q;
  assign o_ad_oe_n = ad_oe_n_q;
  assign o_rd_take = take_q;
  assign o_rd_addr = req_q.addr;
  assign o_arb_hold = hold_q;
  assign o_local_block = block_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_err_code_held: assert property (
    (state_q == pbt_pkg::PBT_ERR && !(eoc && rqr) && !i_exc) |=>
      (state_q == pbt_pkg::PBT_ERR && sc4_on && $stable(lvl_q[3:1])))
    else $error("error code not held until end of cycle");

  a_nack_answer: assert property (
    (state_q == pbt_pkg::PBT_IDLE && req_ph && sel_c && !bcast_c && !i_exc &&
     !tnu_c && !werr_c && i_busy) |=> (lvl_q == {pbt_pkg::ERR_NACK, 1'b0}))
    else $error("busy replier did not answer nack");

  a_width_answer: assert property (
    (state_q == pbt_pkg::PBT_IDLE && req_ph && sel_c && !bcast_c && !i_exc &&
     !tnu_c && werr_c) |=> (lvl_q == {pbt_pkg::ERR_WIDTH, 1'b0}))
    else $error("width error not answered");

  a_tnu_first: assert property (
    (state_q == pbt_pkg::PBT_IDLE && req_ph && sel_c && !bcast_c && !i_exc && tnu_c) |=>
      (state_q == pbt_pkg::PBT_ERR && sc4_on && lvl_q[3:1] == pbt_pkg::ERR_TNU))
    else $error("transfer not understood lost its priority");

  a_cont_answer: assert property (
    (state_q == pbt_pkg::PBT_DATA && !hs && !i_exc && rqr &&
     pend_q == pbt_pkg::ERR_CONT) |=> (state_q == pbt_pkg::PBT_ERR && sc4_on &&
     lvl_q[3:1] == pbt_pkg::ERR_CONT))
    else $error("continuation error not signalled");

  a_data_answer: assert property (
    (state_q == pbt_pkg::PBT_DATA && take_d && i_rd_err && !i_exc) |=>
      (lvl_q[3:1] == pbt_pkg::ERR_DATA && !o_ad_oe_n))
    else $error("data error not signalled with its data");

  a_suspend_err: assert property (
    (state_q == pbt_pkg::PBT_ERR) |-> (!push && !take_d))
    else $error("work went on after an agent error");

  a_bcast_quiet: assert property (
    (state_q != pbt_pkg::PBT_IDLE && req_q.bcast) |-> (oe_n_q == 4'hF))
    else $error("replier drove control lines in a broadcast");

  a_eoc_ends: assert property (
    (state_q == pbt_pkg::PBT_DATA && hs && eoc) |=> (state_q == pbt_pkg::PBT_IDLE))
    else $error("end of cycle did not close the sequence");

  a_req_stable: assert property (
    (state_q == pbt_pkg::PBT_DATA && $past(state_q) == pbt_pkg::PBT_DATA) |->
      ($stable(req_q.space) && $stable(req_q.width) && $stable(req_q.write)))
    else $error("operation parameters changed mid sequence");

  a_lock_hold: assert property (
    lock [*2] |-> (o_arb_hold && (!$past(block_q) || o_local_block)))
    else $error("lock not followed by hold and block");
endmodule
`default_nettype wire
